// File: hw/pthr_pkg.sv
// package: offsets, reset values and carrier types for the proximity threshold bank
package pthr_pkg;
  localparam logic [7:0] PTHR_OFS_P1_LOW = 8'h11;
  localparam logic [7:0] PTHR_OFS_P1_HIGH = 8'h12;
  localparam logic [7:0] PTHR_OFS_P2_LOW = 8'h13;
  localparam logic [7:0] PTHR_OFS_P2_HIGH = 8'h14;
  localparam logic [7:0] PTHR_RESET_BYTE = 8'h00;
  localparam logic [7:0] PTHR_UNMAPPED_READ = 8'h00;

  // register access from the serial interface engine
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pthr_req_t;

  // one proximity measurement from the sequencer
  typedef struct packed {
    logic valid;
    logic chan_two;
    logic [15:0] value;
  } pthr_meas_t;

  // whole state of the bank
  typedef struct packed {
    logic [7:0] p1_low;
    logic [7:0] p1_high;
    logic [7:0] p2_low;
    logic [7:0] p2_high;
    logic [7:0] rdata;
    logic rvalid;
    logic p1_above;
    logic p2_above;
    logic p1_event;
    logic p2_event;
  } pthr_state_t;
endpackage : pthr_pkg

// File: hw/pthr_regs.sv
// module: proximity threshold byte registers and threshold comparison
//
// Notes on behaviour
// - channel-1 threshold 16 bits; high byte read/write at 0x12.
// - channel-1 threshold low byte read/write at 0x11.
// - channel-1 measurements compared with channel-1 threshold to request interrupt.
// - channel-2 threshold 16 bits; low byte 0x13, high byte 0x14.
// - channel-2 measurements compared with channel-2 threshold to request interrupt.
// - every threshold byte resets to zero and is readable and writable.
// - a half-written threshold may be applied by a running measurement.
// - legacy mode: channel-1 threshold is the byte at 0x11, zero-extended to 16 bits.
// - legacy mode: channel-2 threshold is the byte at 0x13, zero-extended to 16 bits.
`timescale 1ns/100ps
module pthr_regs
  import pthr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire pthr_req_t req_i,
  input wire logic legacy_i,
  input wire pthr_meas_t meas_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [15:0] prox1_threshold_o,
  output logic [15:0] prox2_threshold_o,
  output logic prox1_above_o,
  output logic prox2_above_o,
  output logic prox1_event_o,
  output logic prox2_event_o
);
  pthr_state_t st;
  pthr_state_t next_st;
  logic [15:0] prox1_threshold;
  logic [15:0] prox2_threshold;
  logic [15:0] meas_thr;
  logic meas_above;

  // ----------------------------------------
  // effective thresholds
  // ----------------------------------------
  always_comb begin
    prox1_threshold = {st.p1_high, st.p1_low};
    prox2_threshold = {st.p2_high, st.p2_low};
    if (legacy_i) begin
      prox1_threshold = {8'h00, st.p1_low};
    end
    if (legacy_i) begin
      prox2_threshold = {8'h00, st.p2_low};
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.rvalid = req_i.rd_en;
    next_st.p1_event = 1'b0;
    next_st.p2_event = 1'b0;
    if (req_i.wr_en) begin
      case (req_i.addr)
        PTHR_OFS_P1_LOW: next_st.p1_low = req_i.wdata;
        PTHR_OFS_P1_HIGH: next_st.p1_high = req_i.wdata;
        PTHR_OFS_P2_LOW: next_st.p2_low = req_i.wdata;
        PTHR_OFS_P2_HIGH: next_st.p2_high = req_i.wdata;
        default: next_st = next_st;
      endcase
    end
    if (req_i.rd_en) begin
      case (req_i.addr)
        PTHR_OFS_P1_LOW: next_st.rdata = st.p1_low;
        PTHR_OFS_P1_HIGH: next_st.rdata = st.p1_high;
        PTHR_OFS_P2_LOW: next_st.rdata = st.p2_low;
        PTHR_OFS_P2_HIGH: next_st.rdata = st.p2_high;
        default: next_st.rdata = PTHR_UNMAPPED_READ;
      endcase
    end
    meas_thr = meas_i.chan_two ? prox2_threshold : prox1_threshold;
    meas_above = meas_i.value > meas_thr;
    if (meas_i.valid) begin
      if (meas_i.chan_two) begin
        next_st.p2_event = meas_above != st.p2_above;
        next_st.p2_above = meas_above;
      end else begin
        next_st.p1_event = meas_above != st.p1_above;
        next_st.p1_above = meas_above;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{p1_low: PTHR_RESET_BYTE, p1_high: PTHR_RESET_BYTE,
              p2_low: PTHR_RESET_BYTE, p2_high: PTHR_RESET_BYTE,
              rdata: PTHR_RESET_BYTE, default: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign rvalid_o = st.rvalid;
  assign prox1_threshold_o = prox1_threshold;
  assign prox2_threshold_o = prox2_threshold;
  assign prox1_above_o = st.p1_above;
  assign prox2_above_o = st.p2_above;
  assign prox1_event_o = st.p1_event;
  assign prox2_event_o = st.p2_event;
endmodule : pthr_regs

// File: verification/pthr_host.sv
// host model issuing register accesses
`timescale 1ns/100ps
module pthr_host import pthr_pkg::*; (input wire logic ref_clk_i, output pthr_req_t req_o);
  initial req_o = '0;
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(negedge ref_clk_i) req_o = '{w, !w, a, d};
    @(negedge ref_clk_i) req_o = '0;
  endtask : acc
endmodule : pthr_host

// File: verification/pthr_regs_properties.sv
// bank port checker
`timescale 1ns/100ps
module pthr_regs_properties import pthr_pkg::*; (input logic ref_clk_i, rst_n_i, legacy_i,
  rvalid_o, prox1_above_o, prox1_event_o, input pthr_req_t req_i, input pthr_meas_t meas_i,
  input logic [15:0] prox1_threshold_o, prox2_threshold_o);
  wire [7:0] a = req_i.wr_en ? req_i.addr : 8'h00;
  wire [15:0] t = prox1_threshold_o, u = prox2_threshold_o;
  wire m = meas_i.valid && !meas_i.chan_two;
  logic [7:0] d;
  logic g;
  always_ff @(posedge ref_clk_i) {d, g} <= {req_i.wdata, meas_i.value > t};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_ok_a: assert property (1 |=> rvalid_o == $past(req_i.rd_en)) else $error("rd");
  hi_one_a: assert property (a == 8'h12 && !legacy_i |=> t[15:8] == d) else $error("h1");
  lo_one_a: assert property (a == 8'h11 |=> t[7:0] == d) else $error("l1");
  hi_two_a: assert property (a == 8'h14 && !legacy_i |=> u[15:8] == d) else $error("h2");
  legacy_a: assert property (legacy_i |-> !{t[15:8], u[15:8]}) else $error("lg");
  cmp_one_a: assert property (m |=> prox1_above_o == g) else $error("cmp");
  evt_one_a: assert property (prox1_event_o == $changed(prox1_above_o)) else $error("ev");
  keep_lo_a: assert property (a == 8'h12 |=> $stable(t[7:0])) else $error("kp");
endmodule : pthr_regs_properties
bind pthr_regs pthr_regs_properties pthr_regs_properties_i (.*);

// File: verification/testbench.sv
// bank bench
`timescale 1ns/100ps
`define CK(n,e,s) begin samples_checked++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module testbench import pthr_pkg::*;;
  logic ref_clk_i = 0, rst_n_i = 0, legacy_i = 0, rvalid_o;
  logic prox1_above_o, prox2_above_o, prox1_event_o, prox2_event_o;
  logic [7:0] rdata_o;
  logic [15:0] prox1_threshold_o, prox2_threshold_o;
  pthr_req_t req_i;
  pthr_meas_t meas_i = '0;
  int fails = 0, samples_checked = 0;
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  pthr_host pthr_host_i (.ref_clk_i, .req_o(req_i));
  pthr_regs pthr_regs_i (.*);
  task automatic rd(input logic [7:0] a, e);
    pthr_host_i.acc(1'b0, a, 8'h00);
    `CK("rd", {1'b1, e}, {rvalid_o, rdata_o})
  endtask : rd
  task automatic ms(input logic c, input logic [15:0] v, input logic [3:0] e);
    @(negedge ref_clk_i) meas_i = '{1'b1, c, v};
    @(negedge ref_clk_i) meas_i = '0;
    `CK("ms", e, {prox1_above_o, prox1_event_o, prox2_above_o, prox2_event_o})
  endtask : ms
  task automatic t_regs;
    for (int i = 0; i < 5; i++) rd(8'(8'h11 + i), 8'h00);
    for (int i = 0; i < 5; i++) pthr_host_i.acc(1'b1, 8'(8'h11 + i), 8'(8'hA1 + i));
    for (int i = 0; i < 5; i++) rd(8'(8'h11 + i), i < 4 ? 8'(8'hA1 + i) : 8'h00);
    `CK("thr", 32'hA2A1A4A3, {prox1_threshold_o, prox2_threshold_o})
  endtask : t_regs
  task automatic t_meas;
    pthr_host_i.acc(1'b1, 8'h12, 8'h10);
    `CK("torn", 16'h10A1, prox1_threshold_o)
    ms(0, 16'h10A2, 4'hC);
    ms(0, 16'h10A1, 4'h4);
    ms(1, 16'hA4A4, 4'h3);
    ms(1, 16'hA4A3, 4'h1);
    legacy_i = 1;
    ms(0, 16'h00A2, 4'hC);
    ms(1, 16'h00A4, 4'hB);
  endtask : t_meas
  task automatic conclude;
    $display("fails %0d of %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial #20000 begin
    fails++;
    conclude;
  end
  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_n_i = 1;
    t_regs;
    t_meas;
    conclude;
  end
endmodule : testbench
